// ==== core/gdio_map.svh ====
`ifndef GDIO_MAP_SVH
`define GDIO_MAP_SVH

`define GDIO_OFS_DATA 4'h0
`define GDIO_OFS_DIR 4'h1
`define GDIO_OFS_PINS 4'h2
`define GDIO_OFS_MCU 4'h3

`define GDIO_PUD_BIT 4
`define GDIO_BITOP_VAL 3
`define GDIO_RST_BYTE 8'h00
`define GDIO_RST_BIT 1'h0
`define GDIO_SYNC_STAGES 1

`endif

// ==== core/gdio_pkg.sv ====
package gdio_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic bit_op;
  } gdio_req_t;

  typedef struct packed {
    logic oe;
    logic out;
    logic pu;
  } gdio_pad_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic global_pullup_disable;
    logic [7:0] din_en;
    logic [7:0] rdata;
    logic [7:0] pad_oe;
    logic [7:0] pad_out;
    logic [7:0] pad_pu;
  } gdio_state_t;

  typedef struct packed {
    logic lat;
    logic smp;
  } gdio_sync_t;

endpackage

// ==== core/gdio_sync.sv ====
`timescale 1ns/1ps
`include "gdio_map.svh"

module gdio_sync (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] din_en,
  output logic [7:0] sample
);
  logic [7:0] lat_q;
  logic [7:0] smp_q;

  // falling edge stands in for the low-phase latch close
  always_ff @(negedge clock or negedge rstn) begin
    if (!rstn) begin
      lat_q <= `GDIO_RST_BYTE;
    end else begin
      lat_q <= pin_i & din_en; // [RQ12] [RQ20]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      smp_q <= `GDIO_RST_BYTE;
    end else begin
      smp_q <= lat_q; // [RQ12] [RQ13]
    end
  end

  assign sample = smp_q;
endmodule

// ==== core/gdio_pin.sv ====
`timescale 1ns/1ps

module gdio_pin (
  input wire logic dir_q,
  input wire logic data_q,
  input wire logic dir_we,
  input wire logic dir_wv,
  input wire logic dat_we,
  input wire logic dat_wv,
  input wire logic toggle,
  input wire logic global_pullup_disable,
  input wire logic alt_sel,
  input wire logic alt_oe,
  input wire logic alt_val,
  output logic dir_d,
  output logic data_d,
  output gdio_pkg::gdio_pad_t pad
);
  always_comb begin
    dir_d = dir_we ? dir_wv : dir_q; // [RQ10]
    data_d = dat_we ? dat_wv : data_q; // [RQ10]
    if (toggle) begin
      data_d = ~data_q; // [RQ6]
    end
    // override touches only its own pin
    if (alt_sel) begin
      pad.oe = alt_oe; // [RQ18]
      pad.out = alt_val;
      pad.pu = 1'h0;
    end else begin
      pad.oe = dir_d; // [RQ1]
      pad.out = dir_d & data_d; // [RQ4]
      pad.pu = ~dir_d & data_d & ~global_pullup_disable; // [RQ2] [RQ3] [RQ9]
    end
  end
endmodule

// ==== core/gdio_port.sv ====
// Functional notes
// RQ1: direction one drives pin, zero makes input
// RQ2: input with output bit one enables pull-up
// RQ3: pull-up off on output or zero bit
// RQ4: output drives the output-value bit level
// RQ5: reset tri-states all pins asynchronously
// RQ6: writing one to sample register toggles output
// RQ7: sample location read-only, others read/write
// RQ8: three locations: data, direction, input samples
// RQ9: global disable kills every pull-up
// RQ10: single-bit operations touch only addressed bit
// RQ11: sample shows pin level in any direction
// RQ12: low-phase latch then rising-edge register
// RQ13: pin change seen after half to 1.5 cycles
// RQ14: own write seen after one synchroniser period
// RQ15: software idles one instruction before readback
// RQ16: tri-state to high passes pull-up or low
// RQ17: pull-up to low passes tri-state or high
// RQ18: alternate function leaves other pins normal
// RQ19: pull-up disable is control bit four
// RQ20: deep sleep clamps input path to ground
// RQ21: enabled external interrupt pins escape clamp
// RQ22: eight pins per port, one bit each
// RQ23: reset clears direction and output bits
// RQ24: writing zero to sample location does nothing
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "gdio_map.svh"

module gdio_port (
  input wire logic clock,
  input wire logic rstn,
  input gdio_pkg::gdio_req_t req,
  output logic [7:0] rdata,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pu,
  input wire logic sleep_deep,
  input wire logic [7:0] ext_int_en,
  input wire logic [7:0] alt_sel,
  input wire logic [7:0] alt_oe,
  input wire logic [7:0] alt_val
);
  gdio_pkg::gdio_state_t s_q;
  gdio_pkg::gdio_state_t s_d;
  gdio_pkg::gdio_pad_t pad [8];
  logic [7:0] sample;
  logic [7:0] dir_n;
  logic [7:0] data_n;
  logic [7:0] mask;
  logic [7:0] wval;
  logic [7:0] dir_we;
  logic [7:0] dat_we;
  logic [7:0] toggle;
  logic pud_n;
  logic wr_data;
  logic wr_dir;
  logic wr_pins;
  logic wr_mcu;

  // bit operation: index in wdata[2:0], value in wdata[3]
  assign mask = req.bit_op ? (8'h01 << req.wdata[2:0]) : 8'hFF;
  assign wval = req.bit_op ? {8{req.wdata[`GDIO_BITOP_VAL]}} : req.wdata;
  assign wr_data = req.wr && (req.addr == `GDIO_OFS_DATA); // [RQ8]
  assign wr_dir = req.wr && (req.addr == `GDIO_OFS_DIR); // [RQ8]
  assign wr_pins = req.wr && (req.addr == `GDIO_OFS_PINS); // [RQ8]
  assign wr_mcu = req.wr && (req.addr == `GDIO_OFS_MCU);
  assign dir_we = wr_dir ? mask : 8'h00; // [RQ10]
  assign dat_we = wr_data ? mask : 8'h00; // [RQ10]
  // sample location stores nothing; ones toggle, zeros are ignored
  assign toggle = wr_pins ? (mask & wval) : 8'h00; // [RQ6] [RQ7] [RQ24]

  always_comb begin
    pud_n = s_q.global_pullup_disable;
    if (wr_mcu && (!req.bit_op || req.wdata[2:0] == 3'(`GDIO_PUD_BIT))) begin
      pud_n = req.bit_op ? req.wdata[`GDIO_BITOP_VAL] : req.wdata[`GDIO_PUD_BIT]; // [RQ19]
    end
  end

  // one slice per pin, eight pins
  for (genvar i = 0; i < 8; i++) begin : g_pin // [RQ22]
    gdio_pin u_pin (
      .dir_q(s_q.dir[i]),
      .data_q(s_q.data[i]),
      .dir_we(dir_we[i]),
      .dir_wv(wval[i]),
      .dat_we(dat_we[i]),
      .dat_wv(wval[i]),
      .toggle(toggle[i]),
      .global_pullup_disable(pud_n),
      .alt_sel(alt_sel[i]),
      .alt_oe(alt_oe[i]),
      .alt_val(alt_val[i]),
      .dir_d(dir_n[i]),
      .data_d(data_n[i]),
      .pad(pad[i])
    );
  end

  gdio_sync u_sync (
    .clock(clock),
    .rstn(rstn),
    .pin_i(pin_i),
    .din_en(s_q.din_en),
    .sample(sample)
  );

  always_comb begin
    s_d = s_q;
    s_d.dir = dir_n; // [RQ1]
    s_d.data = data_n;
    s_d.global_pullup_disable = pud_n; // [RQ9]
    // wake-capable pins keep their input path during deep sleep
    s_d.din_en = {8{~sleep_deep}} | ext_int_en; // [RQ20] [RQ21]
    for (int i = 0; i < 8; i++) begin
      s_d.pad_oe[i] = pad[i].oe;
      s_d.pad_out[i] = pad[i].out;
      s_d.pad_pu[i] = pad[i].pu;
    end
    s_d.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `GDIO_OFS_DATA: s_d.rdata = s_q.data; // [RQ7]
        `GDIO_OFS_DIR: s_d.rdata = s_q.dir; // [RQ7]
        `GDIO_OFS_PINS: s_d.rdata = sample; // [RQ11] [RQ14]
        `GDIO_OFS_MCU: s_d.rdata = 8'(s_q.global_pullup_disable) << `GDIO_PUD_BIT;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // all-zero reset: every driver off, no pull-up, without a clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0; // [RQ5] [RQ23]
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign pin_o = s_q.pad_out; // [RQ4]
  assign pin_oe = s_q.pad_oe; // [RQ1] [RQ5]
  assign pin_pu = s_q.pad_pu; // [RQ2]
endmodule

// ==== test/gdio_pads.sv ====
`timescale 1ns/1ps
module gdio_pads (
  input logic [7:0] pin_o,
  input logic [7:0] pin_oe,
  input logic [7:0] ext,
  output logic [7:0] lvl
);
  // board drives released pins, so a weak pull-up never decides the level
  assign lvl = (pin_oe & pin_o) | (~pin_oe & ext);
endmodule

// ==== test/gdio_port_chk.sv ====
`timescale 1ns/1ps
module gdio_port_chk (
  input logic clock,
  input logic rstn,
  input gdio_pkg::gdio_req_t req,
  input logic [7:0] rdata,
  input logic [7:0] pin_i,
  input logic [7:0] pin_o,
  input logic [7:0] pin_oe,
  input logic [7:0] pin_pu,
  input logic sleep_deep,
  input logic [7:0] ext_int_en,
  input logic [7:0] alt_sel,
  input logic [7:0] alt_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_idle; !req.rd |=> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata");
  property p_dir; req.wr && !req.bit_op && req.addr == 4'h1 |=> pin_oe == $past(req.wdata);
  endproperty
  a_dir: assert property (p_dir) else $error("dir");
  property p_bit; req.wr && req.bit_op && req.addr == 4'h1 |=>
    ((pin_oe ^ $past(pin_oe)) & ~(8'h01 << $past(req.wdata[2:0]))) == 8'h00; endproperty
  a_bit: assert property (p_bit) else $error("bit op");
  property p_tog; req.wr && !req.bit_op && req.addr == 4'h2 |=>
    ((pin_o ^ $past(pin_o)) & pin_oe) == ($past(req.wdata) & pin_oe); endproperty
  a_tog: assert property (p_tog) else $error("toggle");
  property p_pud; req.wr && !req.bit_op && req.addr == 4'h3 && req.wdata[4] |=>
    pin_pu == 8'h00; endproperty
  a_pud: assert property (p_pud) else $error("pull-up");
  property p_excl; (pin_oe & pin_pu) == 8'h00; endproperty
  a_excl: assert property (p_excl) else $error("pull-up on output");
  // input path enable is registered, so the clamp lags sleep by one cycle
  property p_smp; req.rd && req.addr == 4'h2 && $stable(pin_i) && !$past(sleep_deep) |=>
    rdata == $past(pin_i); endproperty
  a_smp: assert property (p_smp) else $error("sample");
  property p_clamp; req.rd && req.addr == 4'h2 && $past(sleep_deep) |=>
    (rdata & ~$past(ext_int_en, 2)) == 8'h00; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp");
  property p_alt; (|alt_sel) |=> ((pin_oe ^ $past(alt_oe)) & $past(alt_sel)) == 8'h00;
  endproperty
  a_alt: assert property (p_alt) else $error("override");
  property p_rst; disable iff (1'b0) !rstn |-> (pin_oe | pin_pu) == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("not released");
endmodule
bind gdio_port gdio_port_chk u_chk (.clock(clock), .rstn(rstn), .req(req), .rdata(rdata),
  .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu), .sleep_deep(sleep_deep),
  .ext_int_en(ext_int_en), .alt_sel(alt_sel), .alt_oe(alt_oe));

// ==== test/tb_general_digital_io_port.sv ====
`timescale 1ns/1ps
module tb_general_digital_io_port;
  logic clock = 1'b0;
  logic rstn;
  logic sleep_deep = 1'b0;
  logic [7:0] ext_int_en = 8'h00;
  logic [7:0] alt_sel = 8'h00;
  logic [7:0] alt_oe = 8'h00;
  logic [7:0] alt_val = 8'h00;
  logic [7:0] ext = 8'h50;
  gdio_pkg::gdio_req_t req = '0;
  logic [7:0] rdata, pin_i, pin_o, pin_oe, pin_pu;
  int err_count = 0;
  int checks_done = 0;
  always #2 clock = ~clock;
  gdio_pads u_pads (.pin_o(pin_o), .pin_oe(pin_oe), .ext(ext), .lvl(pin_i));
  gdio_port u_dut (.clock(clock), .rstn(rstn), .req(req), .rdata(rdata), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu), .sleep_deep(sleep_deep),
    .ext_int_en(ext_int_en), .alt_sel(alt_sel), .alt_oe(alt_oe), .alt_val(alt_val));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %0t got %h", $time, g);
    end
  endtask
  task automatic acc(input logic [3:0] a, input logic [7:0] d, input logic w, input logic b);
    @(posedge clock);
    req <= '{a, d, w, !w, b};
    @(posedge clock);
    req <= '0;
    @(negedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    acc(a, 8'h00, 1'b0, 1'b0);
    chk(rdata, e);
  endtask
  task automatic pins(input logic [7:0] oe, input logic [7:0] o, input logic [7:0] pu);
    chk(pin_oe, oe);
    chk(pin_o & pin_oe, o);
    chk(pin_pu, pu);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    // an event at time zero, so the flops see reset before the first edge
    rstn <= 1'b0;
    repeat (6) @(posedge clock);
    pins(8'h00, 8'h00, 8'h00);
    rstn <= 1'b1;
    rd(4'h1, 8'h00);
    acc(4'h0, 8'hC3, 1'b1, 1'b0);
    acc(4'h1, 8'h0F, 1'b1, 1'b0);
    pins(8'h0F, 8'h03, 8'hC0);
    rd(4'h2, 8'h53);
    acc(4'h3, 8'h10, 1'b1, 1'b0);
    pins(8'h0F, 8'h03, 8'h00);
    rd(4'h3, 8'h10);
    acc(4'h3, 8'h00, 1'b1, 1'b0);
    acc(4'h1, 8'h0F, 1'b1, 1'b1);
    pins(8'h8F, 8'h83, 8'h40);
    acc(4'h2, 8'h81, 1'b1, 1'b0);
    acc(4'h2, 8'h00, 1'b1, 1'b0);
    rd(4'h0, 8'h42);
    rd(4'h2, 8'h52);
    rd(4'h1, 8'h8F);
    rd(4'hF, 8'h00);
    @(posedge clock);
    ext <= 8'h20;
    rd(4'h2, 8'h22);
    @(posedge clock);
    sleep_deep <= 1'b1;
    ext_int_en <= 8'h20;
    @(posedge clock);
    rd(4'h2, 8'h20);
    @(posedge clock);
    sleep_deep <= 1'b0;
    ext_int_en <= 8'h00;
    alt_sel <= 8'h40;
    alt_oe <= 8'h40;
    alt_val <= 8'h40;
    @(posedge clock);
    @(negedge clock);
    pins(8'hCF, 8'h42, 8'h00);
    @(posedge clock);
    alt_sel <= 8'h00;
    alt_oe <= 8'h00;
    alt_val <= 8'h00;
    @(posedge clock);
    @(negedge clock);
    pins(8'h8F, 8'h02, 8'h40);
    acc(4'h0, 8'h06, 1'b1, 1'b1);
    acc(4'h1, 8'h0E, 1'b1, 1'b1);
    pins(8'hCF, 8'h02, 8'h00);
    @(posedge clock);
    rstn <= 1'b0;
    #1 pins(8'h00, 8'h00, 8'h00);
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd(4'h1, 8'h00);
    rd(4'h0, 8'h00);
    summarize();
  end
endmodule
